// ### core/pllc_ctrl.sv
// Purpose: Register control of the on-chip loop clock multiplier
// Assumes: SFR port strobes are one cycle wide and synchronous
// Notes:   The analog loop sits outside; it reports lock on loop_locked
//
// How it works
// - Lock reads at control bit four
// - Source bit picks internal or external reference
// - Enable low holds loop in reset
// - Power bit low switches bias generator off
// - Unused upper bits read zero, ignore writes
// - Pre-divide by field, zero means 32
// - Multiply by field, zero means 256
// - Output equals reference times multiply over divide
`timescale 1ns/10ps
`default_nettype none
module pllc_ctrl (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    // SFR port
    input  wire logic [7:0]                   sfr_addr,
    input  wire logic                         sfr_wr,
    input  wire logic                         sfr_rd,
    input  wire logic [7:0]                   sfr_wdata,
    output logic      [7:0]                   sfr_rdata,
    // Analog loop status
    input  wire logic                         loop_locked,
    // Analog loop controls
    output logic                              bias_power_on,
    output logic                              loop_hold_reset,
    output logic                              reference_source_select,
    output logic      [pllc_pkg::PLLC_DIV_W:0] predivide_factor,
    output logic      [pllc_pkg::PLLC_MUL_W:0] multiply_factor,
    output logic      [1:0]                   oscillator_range_select,
    output logic      [3:0]                   loop_filter_range,
    output logic                              lock_indicator
);
    import pllc_pkg::*;

    pllc_state_t s_q;
    pllc_state_t s_d;
    logic        wr_ctrl;
    logic        wr_div;
    logic        wr_mul;
    logic        wr_flt;

    // Address decode for writes
    always_comb
    begin
        wr_ctrl = 1'b0;
        wr_div  = 1'b0;
        wr_mul  = 1'b0;
        wr_flt  = 1'b0;
        if (sfr_addr == PLLC_ADDR_CTRL)
        begin
            wr_ctrl = sfr_wr;
        end
        else if (sfr_addr == PLLC_ADDR_DIV)
        begin
            wr_div = sfr_wr;
        end
        else if (sfr_addr == PLLC_ADDR_MUL)
        begin
            wr_mul = sfr_wr;
        end
        else if (sfr_addr == PLLC_ADDR_FLT)
        begin
            wr_flt = sfr_wr;
        end
    end

    // Next state: writes, lock tracking, read data
    always_comb
    begin
        s_d = s_q;
        if (wr_ctrl)
        begin
            // Bit three and the top bits are not stored; lock is read only
            s_d.src = sfr_wdata[PLLC_BIT_SRC];
            s_d.en  = sfr_wdata[PLLC_BIT_EN];
            s_d.pwr = sfr_wdata[PLLC_BIT_PWR];
        end
        if (wr_div)
        begin
            s_d.div = sfr_wdata[PLLC_DIV_W-1:0];
        end
        if (wr_mul)
        begin
            s_d.mul = sfr_wdata;
        end
        if (wr_flt)
        begin
            s_d.flt = sfr_wdata[PLLC_FLT_W-1:0];
        end
        // Lock only counts while powered and running, so a stale
        // report from the analog side cannot leak through a hold
        s_d.lock = s_d.pwr && s_d.en && loop_locked;
        // Registered read answer, zero for anything unmapped
        s_d.rdata = PLLC_ZERO;
        if (sfr_rd)
        begin
            if (sfr_addr == PLLC_ADDR_CTRL)
            begin
                s_d.rdata[PLLC_BIT_LOCK] = s_q.lock;
                s_d.rdata[PLLC_BIT_SRC]  = s_q.src;
                s_d.rdata[PLLC_BIT_EN]   = s_q.en;
                s_d.rdata[PLLC_BIT_PWR]  = s_q.pwr;
            end
            else if (sfr_addr == PLLC_ADDR_DIV)
            begin
                s_d.rdata[PLLC_DIV_W-1:0] = s_q.div;
            end
            else if (sfr_addr == PLLC_ADDR_MUL)
            begin
                s_d.rdata = s_q.mul;
            end
            else if (sfr_addr == PLLC_ADDR_FLT)
            begin
                s_d.rdata[PLLC_FLT_W-1:0] = s_q.flt;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_q.rdata <= PLLC_ZERO;
            s_q.lock  <= PLLC_RST_CTRL[PLLC_BIT_LOCK];
            s_q.src   <= PLLC_RST_CTRL[PLLC_BIT_SRC];
            s_q.en    <= PLLC_RST_CTRL[PLLC_BIT_EN];
            s_q.pwr   <= PLLC_RST_CTRL[PLLC_BIT_PWR];
            s_q.div   <= PLLC_RST_DIV[PLLC_DIV_W-1:0];
            s_q.mul   <= PLLC_RST_MUL;
            s_q.flt   <= PLLC_RST_FLT[PLLC_FLT_W-1:0];
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Effective factors; the loop locks at ref * mult / div
    pllc_factor #(.W(PLLC_DIV_W)) u_div_factor (
        .field  (s_q.div),
        .factor (predivide_factor)
    );
    pllc_factor #(.W(PLLC_MUL_W)) u_mul_factor (
        .field  (s_q.mul),
        .factor (multiply_factor)
    );

    // Controls to the analog loop
    assign sfr_rdata               = s_q.rdata;
    assign bias_power_on           = s_q.pwr;
    assign loop_hold_reset         = !s_q.en;
    assign reference_source_select = s_q.src;
    assign oscillator_range_select = s_q.flt[5:4];
    assign loop_filter_range       = s_q.flt[3:0];
    assign lock_indicator          = s_q.lock;

    // Checks
    AST_LOCK_READ: assert property (@(posedge sys_clk) disable iff (rst)
        sfr_rd && sfr_addr == PLLC_ADDR_CTRL
        |=> sfr_rdata[PLLC_BIT_LOCK] == $past(lock_indicator))
        else $error("lock bit read back wrong");
    AST_SRC_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl
        |=> reference_source_select == $past(sfr_wdata[PLLC_BIT_SRC]))
        else $error("source select did not follow write");
    AST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl && !sfr_wdata[PLLC_BIT_EN] |=> loop_hold_reset)
        else $error("loop not held after enable cleared");
    AST_BIAS: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> bias_power_on == $past(sfr_wdata[PLLC_BIT_PWR]))
        else $error("bias power did not follow write");
    AST_UNUSED_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        sfr_rd && (sfr_addr == PLLC_ADDR_CTRL || sfr_addr == PLLC_ADDR_DIV)
        |=> sfr_rdata[7:5] == 3'h0)
        else $error("unused bits read nonzero");
    AST_DIV_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        wr_div && sfr_wdata[4:0] == 5'h00 |=> predivide_factor == 6'h20)
        else $error("zero pre-divide is not 32");
    AST_DIV_VAL: assert property (@(posedge sys_clk) disable iff (rst)
        wr_div && sfr_wdata[4:0] != 5'h00
        |=> predivide_factor == {1'b0, $past(sfr_wdata[4:0])})
        else $error("pre-divide factor wrong");
    AST_MUL_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        wr_mul && sfr_wdata == 8'h00 |=> multiply_factor == 9'h100)
        else $error("zero multiplier is not 256");
    AST_MUL_VAL: assert property (@(posedge sys_clk) disable iff (rst)
        wr_mul && sfr_wdata != 8'h00
        |=> multiply_factor == {1'b0, $past(sfr_wdata)})
        else $error("multiplier factor wrong");
    // Checked every cycle, so a quick re-enable cannot trip it
    AST_LOCK_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
        !bias_power_on || loop_hold_reset |-> !lock_indicator)
        else $error("lock held while loop stopped");
    AST_LOCK_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_ctrl && bias_power_on && !loop_hold_reset
        |=> lock_indicator == $past(loop_locked))
        else $error("lock flag did not follow running loop");
endmodule : pllc_ctrl
`default_nettype wire

// ### core/pllc_factor.sv
// Purpose: Turns a divide or multiply field into its effective factor
// Assumes: A field of all zeros means two to the field width
// Notes:   Pure combinational, one extra bit of width for the top value
`timescale 1ns/10ps
`default_nettype none
module pllc_factor #(
    parameter int W = 5
) (
    // Field in
    input  wire logic [W-1:0] field,
    // Factor out
    output logic      [W:0]   factor
);
    // Zero field stands for the full range
    always_comb
    begin
        if (field == '0)
        begin
            factor = {1'b1, {W{1'b0}}};
        end
        else
        begin
            factor = {1'b0, field};
        end
    end
endmodule : pllc_factor
`default_nettype wire

// ### shared/pllc_pkg.sv
// Purpose: Constants for the loop clock multiplier control registers
// Assumes: 8-bit special function register port, one system clock
// Notes:   Offsets are the register addresses on the SFR port
package pllc_pkg;
    // Register addresses
    localparam logic [7:0] PLLC_ADDR_CTRL = 8'h89;
    localparam logic [7:0] PLLC_ADDR_DIV  = 8'h8d;
    localparam logic [7:0] PLLC_ADDR_MUL  = 8'h8e;
    localparam logic [7:0] PLLC_ADDR_FLT  = 8'h8f;
    // Control register bit positions
    localparam int PLLC_BIT_PWR  = 0;
    localparam int PLLC_BIT_EN   = 1;
    localparam int PLLC_BIT_SRC  = 2;
    localparam int PLLC_BIT_RSVD = 3;
    localparam int PLLC_BIT_LOCK = 4;
    // Field widths
    localparam int PLLC_DIV_W = 5;
    localparam int PLLC_MUL_W = 8;
    localparam int PLLC_FLT_W = 6;
    // Reset values
    localparam logic [7:0] PLLC_RST_CTRL = 8'h00;
    localparam logic [7:0] PLLC_RST_DIV  = 8'h01;
    localparam logic [7:0] PLLC_RST_MUL  = 8'h01;
    localparam logic [7:0] PLLC_RST_FLT  = 8'h31;
    localparam logic [7:0] PLLC_ZERO     = 8'h00;
    // Whole register state
    typedef struct packed {
        logic [7:0]            rdata;
        logic                  lock;
        logic                  src;
        logic                  en;
        logic                  pwr;
        logic [PLLC_DIV_W-1:0] div;
        logic [PLLC_MUL_W-1:0] mul;
        logic [PLLC_FLT_W-1:0] flt;
    } pllc_state_t;
endpackage : pllc_pkg

// ### tb/pllc_ctrl_tb_top.sv
// Purpose: Self-checking bench for the loop clock multiplier control
// Assumes: Inputs driven 1 ns after the rising edge, fixed seed
// Notes:   Reference model tracks the four registers and the lock flag
`timescale 1ns/10ps
`default_nettype none
module pllc_ctrl_tb_top;
    import pllc_pkg::*;
    // Design signals
    logic       sys_clk, rst, sfr_wr, sfr_rd, loop_locked;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic       bias_power_on, loop_hold_reset, reference_source_select;
    logic       lock_indicator;
    logic [5:0] predivide_factor;
    logic [8:0] multiply_factor;
    logic [1:0] oscillator_range_select;
    logic [3:0] loop_filter_range;
    // Model state and bookkeeping
    logic       m_pwr, m_en, m_src, m_lk;
    logic [4:0] m_dv;
    logic [7:0] m_ml;
    logic [5:0] m_fl;
    logic [7:0] addrs [5] = '{8'h89, 8'h8d, 8'h8e, 8'h8f, 8'h8c};
    logic [3:0] codes [4] = '{4'h1, 4'h3, 4'h7, 4'hf};
    logic [7:0] r_a, r_d;
    int         fails, checks, rnd;

    pllc_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .loop_locked(loop_locked),
        .bias_power_on(bias_power_on), .loop_hold_reset(loop_hold_reset),
        .reference_source_select(reference_source_select),
        .predivide_factor(predivide_factor),
        .multiply_factor(multiply_factor),
        .oscillator_range_select(oscillator_range_select),
        .loop_filter_range(loop_filter_range),
        .lock_indicator(lock_indicator));

    // 40 MHz clock
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    task automatic cmp(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // Read value the registers should show; unmapped reads zero
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            PLLC_ADDR_CTRL: return {3'h0, m_lk, 1'b0, m_src, m_en, m_pwr};
            PLLC_ADDR_DIV:  return {3'h0, m_dv};
            PLLC_ADDR_MUL:  return m_ml;
            PLLC_ADDR_FLT:  return {2'h0, m_fl};
            default:        return 8'h00;
        endcase
    endfunction : exp_rd

    task automatic chk_out;
        cmp("bias", {8'h00, m_pwr}, {8'h00, bias_power_on});
        cmp("hold", {8'h00, !m_en}, {8'h00, loop_hold_reset});
        cmp("src", {8'h00, m_src}, {8'h00, reference_source_select});
        cmp("prediv", (m_dv == 5'h00) ? 9'h020 : {4'h0, m_dv},
            {3'h0, predivide_factor});
        cmp("mult", (m_ml == 8'h00) ? 9'h100 : {1'h0, m_ml},
            multiply_factor);
        cmp("range", {7'h00, m_fl[5:4]}, {7'h00, oscillator_range_select});
        cmp("filter", {5'h00, m_fl[3:0]}, {5'h00, loop_filter_range});
        cmp("lock", {8'h00, m_lk}, {8'h00, lock_indicator});
    endtask : chk_out

    // Idle edge first so strobes never toggle twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        sfr_wr = 1'b0;
        case (a)
            PLLC_ADDR_CTRL: {m_src, m_en, m_pwr} = d[2:0];
            PLLC_ADDR_DIV:  m_dv = d[4:0];
            PLLC_ADDR_MUL:  m_ml = d;
            PLLC_ADDR_FLT:  m_fl = d[5:0];
            default:        ;
        endcase
        m_lk = m_pwr & m_en & loop_locked;
        chk_out();
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        sfr_rd = 1'b0;
        cmp("rdata", {1'h0, exp_rd(a)}, {1'h0, sfr_rdata});
    endtask : rd

    task automatic set_lk(input logic v);
        @(posedge sys_clk);
        #1;
        loop_locked = v;
        @(posedge sys_clk);
        #1;
        m_lk = m_pwr & m_en & v;
        chk_out();
    endtask : set_lk

    task automatic do_rst;
        rst = 1'b1;
        repeat (10) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        {m_pwr, m_en, m_src, m_lk} = 4'h0;
        m_dv = 5'h01;
        m_ml = 8'h01;
        m_fl = 6'h31;
        chk_out();
    endtask : do_rst

    task automatic print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        print_verdict();
    end

    initial
    begin
        {sfr_wr, sfr_rd, loop_locked} = 3'h0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        rnd = $urandom(32'h4f52);
        do_rst();
        foreach (addrs[i]) rd(addrs[i]);
        // Power first, settle, then enable with the external reference
        wr(PLLC_ADDR_CTRL, 8'h01);
        repeat (200) @(posedge sys_clk);
        wr(PLLC_ADDR_CTRL, 8'hf7);
        rd(PLLC_ADDR_CTRL);
        set_lk(1'b1);
        rd(PLLC_ADDR_CTRL);
        wr(PLLC_ADDR_CTRL, 8'h01);
        wr(PLLC_ADDR_CTRL, 8'h00);
        wr(PLLC_ADDR_DIV, 8'h00);
        wr(PLLC_ADDR_MUL, 8'h00);
        wr(PLLC_ADDR_DIV, 8'hff);
        rd(PLLC_ADDR_DIV);
        for (int i = 0; i < 4; i++)
            foreach (codes[j])
            begin
                wr(PLLC_ADDR_FLT, {2'h3, i[1:0], codes[j]});
                rd(PLLC_ADDR_FLT);
            end
        // Random traffic, lock toggling among writes
        repeat (80)
        begin
            r_a = addrs[$urandom_range(4)];
            r_d = 8'($urandom);
            // Random data kept within what software may write
            if (r_a == PLLC_ADDR_FLT)
                r_d[3:0] = codes[$urandom_range(3)];
            if (r_a == PLLC_ADDR_CTRL)
            begin
                r_d[PLLC_BIT_RSVD] = 1'b0;
                r_d[PLLC_BIT_EN] = r_d[PLLC_BIT_EN] & m_pwr & r_d[0];
                if (r_d[PLLC_BIT_EN] && !m_en)
                    repeat (200) @(posedge sys_clk);
            end
            wr(r_a, r_d);
            if ($urandom_range(1) == 1)
                set_lk(1'($urandom));
            rd(addrs[$urandom_range(4)]);
        end
        do_rst();
        rd(PLLC_ADDR_FLT);
        print_verdict();
    end
endmodule : pllc_ctrl_tb_top
`default_nettype wire
